// ---- adc_timing_format_flow_control_tb_top.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adc_timing_format_flow_control_tb_top;
    localparam logic [2:0] A_DIV = atf_pkg::ADDR_CLK_DIV;
    localparam logic [2:0] A_FMT = atf_pkg::ADDR_FORMAT;
    localparam logic [2:0] A_FLW = atf_pkg::ADDR_FLOW;
    logic clk, rst, soft_reset, conv_enable, special_access_grant, trigger_mode;
    logic [1:0] request_source_config;
    atf_pkg::atf_bus_t bus;
    atf_pkg::atf_ireq_t ireq;
    logic [7:0] rdata;
    logic [2:0] resolution_select;
    logic list_loaded, conversion_boundary, period_end, seq_active, end_of_list_seen;
    logic conversion_clock, sample_start, result_justify_select, halted, abort_overrun;
    logic command_error_flag, start_overrun_error_flag, unexpected_restart_error_flag;
    logic hold_seq, load_req;
    int fails, total_checks;

    atf_flow_ctrl #(.DIV_W(7)) dut (.clk(clk), .rst(rst), .soft_reset(soft_reset),
        .conv_enable(conv_enable), .special_access_grant(special_access_grant),
        .trigger_mode(trigger_mode), .request_source_config(request_source_config),
        .bus(bus), .rdata(rdata), .ireq(ireq), .list_loaded(list_loaded),
        .conversion_boundary(conversion_boundary), .period_end(period_end),
        .seq_active(seq_active), .end_of_list_seen(end_of_list_seen),
        .conversion_clock(conversion_clock), .sample_start(sample_start),
        .result_justify_select(result_justify_select),
        .resolution_select(resolution_select), .halted(halted),
        .command_error_flag(command_error_flag),
        .start_overrun_error_flag(start_overrun_error_flag),
        .unexpected_restart_error_flag(unexpected_restart_error_flag),
        .abort_overrun(abort_overrun));

    atf_seq_model far_end (.clk(clk), .rst(rst), .sample_start(sample_start),
        .hold_seq(hold_seq), .load_req(load_req), .list_loaded(list_loaded),
        .conversion_boundary(conversion_boundary), .period_end(period_end),
        .seq_active(seq_active), .end_of_list_seen(end_of_list_seen));

    task automatic stop_test;
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // whole-byte stores only, one write per two cycles
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus = '{we: 1'b1, addr: a, wdata: d};
        cyc(1);
        bus.we = 1'b0;
        cyc(1);
    endtask
    task automatic rdm(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        bus.addr = a;
        cyc(1);
        chk(rdata & m, e);
    endtask
    task automatic ena(input logic e);
        conv_enable = e;
        cyc(4);
    endtask
    task automatic pulse(input logic [3:0] v);
        ireq = v;
        cyc(1);
        ireq = 4'h0;
        cyc(1);
    endtask
    task automatic fmt(input logic [7:0] d, input logic [7:0] e);
        wr(A_FMT, d);
        chk({result_justify_select, 4'h0, resolution_select}, e);
    endtask

    task automatic t_div;
        longint t0;
        int d;
        rdm(3'h2, 8'hFF, 8'h00);
        rdm(A_FLW, 8'hFF, 8'h00);
        for (d = 0; d < 8; d += 5)
        begin
            wr(A_DIV, 8'(d));
            rdm(A_DIV, 8'hFF, 8'(d));
            @(posedge conversion_clock);
            t0 = $time;
            @(posedge conversion_clock);
            chk(8'(($time - t0) / 40), 8'(2 * (d + 1)));
            cyc(1);
        end
        wr(A_DIV, 8'h05);
        ena(1'b1);
        wr(A_DIV, 8'h01);
        rdm(A_DIV, 8'hFF, 8'h05);
        special_access_grant = 1'b1;
        wr(A_DIV, 8'h01);
        rdm(A_DIV, 8'hFF, 8'h01);
        special_access_grant = 1'b0;
        ena(1'b0);
    endtask

    task automatic t_fmt;
        fmt(8'h84, 8'h84);
        rdm(A_FMT, 8'h87, 8'h84);
        fmt(8'h02, 8'h02);
        ena(1'b1);
        fmt(8'h80, 8'h02);
        ena(1'b0);
        fmt(8'h00, 8'h00);
    endtask

    task automatic t_flow;
        int k;
        conv_enable = 1'b1;
        wr(A_FLW, 8'h40);
        rdm(A_FLW, 8'hF0, 8'h00);
        wr(A_FLW, 8'h00);
        rdm(A_FLW, 8'hF0, 8'h00);
        wr(A_FLW, 8'h40);
        wr(A_FLW, 8'h40);
        chk1(start_overrun_error_flag, 1'b1);
        for (k = 0; k < 16 && sample_start !== 1'b1; k++) cyc(1);
        chk1(sample_start, 1'b1);
        rdm(A_FLW, 8'h40, 8'h00);
        hold_seq = 1'b1;
        for (k = 0; k < 30 && sample_start !== 1'b1; k++) cyc(1);
        chk1(sample_start, 1'b1);
        hold_seq = 1'b0;
        ena(1'b0);
        rdm(A_FLW, 8'hFF, 8'h00);
        chk1(start_overrun_error_flag, 1'b0);
    endtask

    task automatic t_abort;
        ena(1'b1);
        hold_seq = 1'b1;
        wr(A_FLW, 8'h20);
        chk1(unexpected_restart_error_flag, 1'b1);
        rdm(A_FLW, 8'h80, 8'h80);
        wr(A_FLW, 8'h80);
        chk1(abort_overrun, 1'b1);
        rdm(A_FLW, 8'h80, 8'h80);
        hold_seq = 1'b0;
        cyc(4);
        rdm(A_FLW, 8'h80, 8'h00);
        ena(1'b0);
    endtask

    task automatic t_restart;
        int m;
        int k;
        for (m = 0; m < 2; m++)
        begin
            trigger_mode = m[0];
            ena(1'b1);
            wr(A_FLW, 8'h30);
            rdm(A_FLW, 8'hE0, m ? 8'h60 : 8'h20);
            load_req = 1'b1;
            cyc(1);
            load_req = 1'b0;
            for (k = 0; k < 8 && rdata[5] !== 1'b0; k++) cyc(1);
            chk(rdata & 8'h60, 8'h00);
            for (k = 0; k < 12 && sample_start !== 1'b1; k++) cyc(1);
            chk1(sample_start === 1'b1 && k > 2 && k < 8, m[0]);
            chk1(unexpected_restart_error_flag, 1'b0);
            ena(1'b0);
        end
        trigger_mode = 1'b0;
    endtask

    task automatic t_reserved;
        logic [7:0] codes [5];
        int i;
        int k;
        codes = '{8'h01, 8'h03, 8'h05, 8'h06, 8'h07};
        for (i = 0; i < 5; i++)
        begin
            wr(A_FMT, codes[i]);
            ena(1'b1);
            wr(A_FLW, 8'h40);
            for (k = 0; k < 20 && command_error_flag !== 1'b1; k++) cyc(1);
            chk({6'h0, halted, command_error_flag}, 8'h03);
            soft_reset = 1'b1;
            cyc(1);
            soft_reset = 1'b0;
            cyc(1);
            chk1(command_error_flag, 1'b0);
            ena(1'b0);
        end
        wr(A_FMT, 8'h00);
    endtask

    task automatic t_internal;
        request_source_config = atf_pkg::SRC_INTERNAL;
        ena(1'b1);
        hold_seq = 1'b1;
        wr(A_FLW, 8'h40);
        rdm(A_FLW, 8'h40, 8'h00);
        pulse(4'h4);
        rdm(A_FLW, 8'h40, 8'h40);
        pulse(4'h4);
        chk1(start_overrun_error_flag, 1'b1);
        pulse(4'h8);
        pulse(4'h8);
        chk1(abort_overrun, 1'b1);
        rdm(A_FLW, 8'h80, 8'h80);
        hold_seq = 1'b0;
        ena(1'b0);
        request_source_config = atf_pkg::SRC_BUS;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #400000;
        fails++;
        stop_test();
    end
    initial
    begin
        fails = 0;
        total_checks = 0;
        rst = 1'b1;
        soft_reset = 1'b0;
        conv_enable = 1'b0;
        special_access_grant = 1'b0;
        trigger_mode = 1'b0;
        request_source_config = atf_pkg::SRC_BUS;
        bus = '0;
        ireq = '0;
        hold_seq = 1'b0;
        load_req = 1'b0;
        cyc(2);
        rst = 1'b0;
        t_div();
        t_fmt();
        t_flow();
        t_abort();
        t_restart();
        t_reserved();
        t_internal();
        stop_test();
    end
endmodule
`default_nettype wire

// ---- atf_clk_div.sv ----
// conversion clock divider from the bus clock
`timescale 1ns/1ns
`default_nettype none
module atf_clk_div #(
    parameter int DIV_W = 7
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [DIV_W-1:0] divide_value,
    output logic conv_clk,
    output logic conv_rise
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic clk_o;
        logic rise;
    } atf_div_st_t;
    atf_div_st_t s_reg;
    atf_div_st_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.rise = 1'b0;
        // toggles every value+1 cycles, so period 2x(value+1), even duty
        if (s_reg.cnt >= divide_value)
        begin
            s_next.cnt = '0;
            s_next.clk_o = ~s_reg.clk_o;
            s_next.rise = ~s_reg.clk_o;
        end
        else
        begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign conv_clk = s_reg.clk_o;
    assign conv_rise = s_reg.rise;

    a_half_period: assert property (@(posedge clk) disable iff (rst)
        $changed(s_reg.clk_o) && $stable(divide_value) |-> s_reg.cnt == '0)
        else $error("divider toggled with nonzero count");
endmodule
`default_nettype wire

// ---- atf_flow_ctrl.sv ----
// How it works
// - divider field writable only when disabled or special access; always readable
// - conversion clock is bus clock over two times (divider plus one)
// - results unsigned; bit 7 zero left-justified, one right-justified
// - resolution 000 eight bits, 010 ten, 100 twelve; others reserved
// - start with reserved resolution sets command error and halts
// - justify and resolution writable only when disabled or special access
// - flow bits modifiable only three bus cycles after enable
// - all flow bits clear while disabled or on soft reset
// - flow bits settable only while enabled; writing zero does nothing
// - restart mode: sample two bus plus two conversion cycles after start
// - in sequence, next sample five bus plus two conversion cycles later
// - trigger mode: restart also raises start; both clear together unless the resolution is reserved
// - trigger mode: sampling five bus cycles after start bit falls
// - abort ends sequence at next boundary, clears when aborted and idle
// - bus write of one to set abort is an overrun, no clear
// - internal abort line may set abort; repeat while set is overrun
// - source config picks bus writes or internal lines for all bits together
// - unexpected restart sets abort and restart error flag
// - start bit begins sequence when idle, clears at first sample; in trigger mode it clears when the sequence starts
// - bus write one to set start keeps it set, sets overrun flag
// - repeated internal start while set sets overrun flag
// - restart bit loads first list command when idle, clears once loaded
// - special access lifts the divider and format write locks; flow bit restrictions stay
`timescale 1ns/1ns
`default_nettype none
module atf_flow_ctrl #(
    parameter int DIV_W = 7
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_reset,
    input wire logic conv_enable,
    input wire logic special_access_grant,
    input wire logic trigger_mode,
    input wire logic [1:0] request_source_config,
    input wire atf_pkg::atf_bus_t bus,
    output logic [7:0] rdata,
    input wire atf_pkg::atf_ireq_t ireq,
    input wire logic list_loaded,
    input wire logic conversion_boundary,
    input wire logic period_end,
    input wire logic seq_active,
    input wire logic end_of_list_seen,
    output logic conversion_clock,
    output logic sample_start,
    output logic result_justify_select,
    output logic [2:0] resolution_select,
    output logic halted,
    output logic command_error_flag,
    output logic start_overrun_error_flag,
    output logic unexpected_restart_error_flag,
    output logic abort_overrun
);
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic justify;
        logic [2:0] res;
        atf_pkg::atf_flow_t flow;
        logic [1:0] en_cnt;
        logic cmd_err;
        logic sequence_start_request_err;
        logic list_restart_request_err;
        logic abort_ovr;
        logic start_wait;
    } atf_st_t;
    atf_st_t s_reg;
    atf_st_t s_next;

    logic conv_rise;
    logic go;
    logic [2:0] go_bus;
    logic [1:0] go_pump;
    logic cfg_ok;
    logic flow_ok;
    logic wr_flow;
    atf_pkg::atf_flow_t req;
    logic res_reserved;
    logic seq_running;

    atf_clk_div #(.DIV_W(DIV_W)) u_div (
        .clk(clk),
        .rst(rst),
        .divide_value(s_reg.div),
        .conv_clk(conversion_clock),
        .conv_rise(conv_rise)
    );

    atf_sample_timer u_tmr (
        .clk(clk),
        .rst(rst),
        .go(go),
        .bus_cycles(go_bus),
        .pump_cycles(go_pump),
        .conv_rise(conv_rise),
        .sample_start(sample_start)
    );

    // format and divider locked during conversion unless special access
    assign cfg_ok = !conv_enable || special_access_grant;
    assign flow_ok = conv_enable && (s_reg.en_cnt == atf_pkg::ENABLE_LATENCY);
    assign wr_flow = bus.we && bus.addr == atf_pkg::ADDR_FLOW;
    assign res_reserved = !(s_reg.res == atf_pkg::RES_8 || s_reg.res == atf_pkg::RES_10
        || s_reg.res == atf_pkg::RES_12);
    assign seq_running = seq_active || s_reg.start_wait;

    // per-bit set requests from the selected source
    always_comb
    begin
        req = '0;
        if (request_source_config == atf_pkg::SRC_BUS)
        begin
            if (wr_flow)
            begin
                req.abort = bus.wdata[atf_pkg::BIT_ABORT];
                req.start = bus.wdata[atf_pkg::BIT_START];
                req.restart = bus.wdata[atf_pkg::BIT_RESTART];
                // ready bit only counts with restart in the same byte
                req.loadok = bus.wdata[atf_pkg::BIT_LOADOK]
                    && bus.wdata[atf_pkg::BIT_RESTART];
            end
        end
        else if (request_source_config == atf_pkg::SRC_INTERNAL)
        begin
            req.abort = ireq.abort;
            req.start = ireq.start;
            req.restart = ireq.restart;
            req.loadok = ireq.loadok && ireq.restart;
        end
    end

    always_comb
    begin
        s_next = s_reg;
        go = 1'b0;
        go_bus = atf_pkg::SAMPLE_DELAY_RESTART_BUS;
        go_pump = atf_pkg::PUMP_CONV_CYCLES;
        if (!conv_enable)
            s_next.en_cnt = 2'h0;
        else if (s_reg.en_cnt != atf_pkg::ENABLE_LATENCY)
            s_next.en_cnt = s_reg.en_cnt + 2'h1;

        if (bus.we && cfg_ok && bus.addr == atf_pkg::ADDR_CLK_DIV)
            s_next.div = bus.wdata[DIV_W-1:0];
        if (bus.we && cfg_ok && bus.addr == atf_pkg::ADDR_FORMAT)
        begin
            s_next.justify = bus.wdata[atf_pkg::BIT_JUSTIFY];
            s_next.res = bus.wdata[2:0];
        end

        if (flow_ok && !s_reg.cmd_err)
        begin
            // set-only: zero writes leave the bits alone
            if (req.abort)
            begin
                if (s_reg.flow.abort)
                    s_next.abort_ovr = 1'b1;
                s_next.flow.abort = 1'b1;
            end
            if (req.start)
            begin
                if (s_reg.flow.start)
                    s_next.sequence_start_request_err = 1'b1;
                s_next.flow.start = 1'b1;
            end
            if (req.restart)
            begin
                s_next.flow.restart = 1'b1;
                if (req.loadok)
                    s_next.flow.loadok = 1'b1;
                if (trigger_mode)
                    s_next.flow.start = 1'b1;
                if (seq_running && !s_reg.flow.abort && !req.abort && !end_of_list_seen)
                begin
                    s_next.flow.abort = 1'b1;
                    s_next.list_restart_request_err = 1'b1;
                end
            end
        end

        // abort completes at boundary; cleared once idle
        if (s_reg.flow.abort && (conversion_boundary || !seq_running) && !req.abort)
        begin
            s_next.flow.abort = 1'b0;
            s_next.start_wait = 1'b0;
        end

        // restart done when first command is loaded
        if (s_reg.flow.restart && list_loaded && !s_reg.flow.abort)
        begin
            s_next.flow.restart = 1'b0;
            s_next.flow.loadok = 1'b0;
            // trigger mode takes the pending start on this same edge, so that
            // both bits fall together instead of start trailing by a cycle
            if (trigger_mode && res_reserved)
                s_next.cmd_err = 1'b1;
            else if (trigger_mode)
            begin
                s_next.flow.start = 1'b0;
                s_next.start_wait = 1'b1;
                go = 1'b1;
                go_bus = atf_pkg::SAMPLE_DELAY_SEQUENCE_START_REQUEST_BUS;
                go_pump = 2'h0;
            end
        end

        // start a sequence from idle
        if (s_reg.flow.start && !seq_running && !s_reg.flow.abort && !s_reg.flow.restart)
        begin
            if (res_reserved)
                s_next.cmd_err = 1'b1;
            else if (trigger_mode)
            begin
                s_next.flow.start = 1'b0;
                s_next.start_wait = 1'b1;
                go = 1'b1;
                go_bus = atf_pkg::SAMPLE_DELAY_SEQUENCE_START_REQUEST_BUS;
                go_pump = 2'h0;
            end
            else
            begin
                s_next.start_wait = 1'b1;
                go = 1'b1;
                go_bus = atf_pkg::SAMPLE_DELAY_RESTART_BUS;
            end
        end
        // no new conversion once disabled; a restart start above keeps its timing
        else if (period_end && seq_active && conv_enable && !go && !s_reg.flow.abort)
        begin
            go = 1'b1;
            go_bus = atf_pkg::SAMPLE_DELAY_SEQ_BUS;
        end

        if (sample_start && s_reg.start_wait)
        begin
            s_next.start_wait = 1'b0;
            if (!trigger_mode)
                s_next.flow.start = 1'b0;
        end

        if (!conv_enable || soft_reset)
        begin
            s_next.flow = '0;
            s_next.start_wait = 1'b0;
            s_next.cmd_err = 1'b0;
            s_next.sequence_start_request_err = 1'b0;
            s_next.list_restart_request_err = 1'b0;
            s_next.abort_ovr = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.div <= atf_pkg::DIV_RESET;
        end
        else
            s_reg <= s_next;
    end

    always_comb
    begin
        rdata = 8'h00;
        case (bus.addr)
            atf_pkg::ADDR_CLK_DIV: rdata[DIV_W-1:0] = s_reg.div;
            atf_pkg::ADDR_FORMAT:
            begin
                rdata[atf_pkg::BIT_JUSTIFY] = s_reg.justify;
                rdata[2:0] = s_reg.res;
            end
            atf_pkg::ADDR_FLOW:
            begin
                rdata[atf_pkg::BIT_ABORT] = s_reg.flow.abort;
                rdata[atf_pkg::BIT_START] = s_reg.flow.start;
                rdata[atf_pkg::BIT_RESTART] = s_reg.flow.restart;
                rdata[atf_pkg::BIT_LOADOK] = s_reg.flow.loadok;
            end
            default: rdata = 8'h00;
        endcase
    end

    assign result_justify_select = s_reg.justify;
    assign resolution_select = s_reg.res;
    assign halted = s_reg.cmd_err;
    assign command_error_flag = s_reg.cmd_err;
    assign start_overrun_error_flag = s_reg.sequence_start_request_err;
    assign unexpected_restart_error_flag = s_reg.list_restart_request_err;
    assign abort_overrun = s_reg.abort_ovr;

    a_flow_cleared: assert property (@(posedge clk) disable iff (rst)
        !conv_enable |=> s_reg.flow == '0)
        else $error("flow bits not cleared while disabled");
    a_enable_latency: assert property (@(posedge clk) disable iff (rst)
        $rose(conv_enable) |-> ##1 (s_reg.flow == '0) [*3])
        else $error("flow bits changed inside enable latency");
    a_div_locked: assert property (@(posedge clk) disable iff (rst)
        conv_enable && !special_access_grant |=> $stable(s_reg.div))
        else $error("divider written while locked");
    a_fmt_locked: assert property (@(posedge clk) disable iff (rst)
        conv_enable && !special_access_grant |=> $stable(s_reg.res) && $stable(s_reg.justify))
        else $error("format written while locked");
    a_start_overrun: assert property (@(posedge clk) disable iff (rst)
        conv_enable && !soft_reset && flow_ok && !s_reg.cmd_err && req.start
        && s_reg.flow.start |=> s_reg.sequence_start_request_err)
        else $error("start overrun not flagged");
    a_res_error: assert property (@(posedge clk) disable iff (rst)
        conv_enable && !soft_reset && s_reg.flow.start && !seq_running && !s_reg.flow.abort
        && !s_reg.flow.restart && res_reserved |=> command_error_flag)
        else $error("reserved resolution not flagged");
    a_abort_overrun: assert property (@(posedge clk) disable iff (rst)
        conv_enable && !soft_reset && flow_ok && !s_reg.cmd_err && req.abort
        && s_reg.flow.abort |=> abort_overrun && s_reg.flow.abort)
        else $error("abort overrun not flagged");
    a_sample_delay: assert property (@(posedge clk) disable iff (rst)
        go && trigger_mode && go_bus == atf_pkg::SAMPLE_DELAY_SEQUENCE_START_REQUEST_BUS
        && !seq_active |-> ##[5:6] sample_start)
        else $error("trigger sample delay wrong");
    a_pair_clear: assert property (@(posedge clk) disable iff (rst)
        trigger_mode && $fell(s_reg.flow.restart) && !s_reg.cmd_err |-> !s_reg.flow.start)
        else $error("restart and start did not fall together");
    a_set_locked: assert property (@(posedge clk) disable iff (rst)
        !flow_ok |=> (s_reg.flow & ~$past(s_reg.flow)) == '0)
        else $error("flow bit set while locked");
    a_loadok_pair: assert property (@(posedge clk) disable iff (rst)
        $rose(s_reg.flow.loadok) |-> s_reg.flow.restart)
        else $error("ready bit set without restart");
    a_abort_held: assert property (@(posedge clk) disable iff (rst)
        conv_enable && !soft_reset && s_reg.flow.abort && seq_running && !conversion_boundary
        |=> s_reg.flow.abort)
        else $error("abort dropped before boundary");
endmodule
`default_nettype wire

// ---- atf_pkg.sv ----
// package: register map, field layout and types for the converter control block
package atf_pkg;
    localparam logic [2:0] ADDR_CLK_DIV = 3'h3;
    localparam logic [2:0] ADDR_FORMAT = 3'h4;
    localparam logic [2:0] ADDR_FLOW = 3'h5;
    localparam int DIV_W = 7;
    localparam logic [DIV_W-1:0] DIV_RESET = 7'h00;
    localparam int BIT_JUSTIFY = 7;
    localparam int BIT_ABORT = 7;
    localparam int BIT_START = 6;
    localparam int BIT_RESTART = 5;
    localparam int BIT_LOADOK = 4;
    localparam logic [2:0] RES_8 = 3'h0;
    localparam logic [2:0] RES_10 = 3'h2;
    localparam logic [2:0] RES_12 = 3'h4;
    localparam logic [1:0] ENABLE_LATENCY = 2'h3;
    localparam logic [2:0] SAMPLE_DELAY_RESTART_BUS = 3'h2;
    localparam logic [2:0] SAMPLE_DELAY_SEQ_BUS = 3'h5;
    localparam logic [2:0] SAMPLE_DELAY_SEQUENCE_START_REQUEST_BUS = 3'h5;
    localparam logic [1:0] PUMP_CONV_CYCLES = 2'h2;
    localparam logic [1:0] SRC_BUS = 2'h0;
    localparam logic [1:0] SRC_INTERNAL = 2'h1;

    typedef struct packed {
        logic abort;
        logic start;
        logic restart;
        logic loadok;
    } atf_flow_t;

    typedef struct packed {
        logic we;
        logic [2:0] addr;
        logic [7:0] wdata;
    } atf_bus_t;

    typedef struct packed {
        logic abort;
        logic start;
        logic restart;
        logic loadok;
    } atf_ireq_t;
endpackage

// ---- atf_sample_timer.sv ----
// delay from a start event to channel sampling: bus cycles then pump cycles
`timescale 1ns/1ns
`default_nettype none
module atf_sample_timer
(
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [2:0] bus_cycles,
    input wire logic [1:0] pump_cycles,
    input wire logic conv_rise,
    output logic sample_start
);
    typedef struct packed {
        logic busy;
        logic [2:0] bus_cnt;
        logic [1:0] pump_cnt;
        logic done;
    } atf_tmr_st_t;
    atf_tmr_st_t s_reg;
    atf_tmr_st_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (go && !s_reg.busy)
        begin
            s_next.busy = 1'b1;
            s_next.bus_cnt = bus_cycles;
            s_next.pump_cnt = pump_cycles;
        end
        else if (s_reg.busy)
        begin
            if (s_reg.bus_cnt > 3'h1)
                s_next.bus_cnt = s_reg.bus_cnt - 3'h1;
            else if (s_reg.pump_cnt == 2'h0)
            begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                s_next.bus_cnt = 3'h0;
            end
            else if (conv_rise)
            begin
                s_next.bus_cnt = 3'h0;
                s_next.pump_cnt = s_reg.pump_cnt - 2'h1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign sample_start = s_reg.done;
endmodule
`default_nettype wire

// ---- atf_seq_model.sv ----
// far-side sequencer model: command loads, sequence runs, list end
`timescale 1ns/1ns
`default_nettype none
module atf_seq_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sample_start,
    input wire logic hold_seq,
    input wire logic load_req,
    output logic list_loaded,
    output logic conversion_boundary,
    output logic period_end,
    output logic seq_active,
    output logic end_of_list_seen
);
    logic [2:0] run_cnt;
    logic [1:0] load_cnt;
    logic eol;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            run_cnt <= 3'h0;
            load_cnt <= 2'h0;
            eol <= 1'b1;
        end
        else
        begin
            // command load answers two cycles after the request
            load_cnt <= load_req ? 2'h2 : (load_cnt != 2'h0 ? load_cnt - 2'h1 : 2'h0);
            if (sample_start)
            begin
                run_cnt <= 3'h6;
                eol <= 1'b0;
            end
            else if (run_cnt != 3'h0)
            begin
                run_cnt <= run_cnt - 3'h1;
                eol <= (run_cnt == 3'h1) ? 1'b1 : eol;
            end
        end
    end
    assign list_loaded = (load_cnt == 2'h1);
    assign conversion_boundary = (run_cnt == 3'h1);
    // a short list ends after one period; only a long list asks for the next one
    assign period_end = (run_cnt == 3'h1) & hold_seq;
    // hold_seq stands for a long list that has not reached its end yet
    assign seq_active = (run_cnt != 3'h0) | hold_seq;
    assign end_of_list_seen = eol & ~hold_seq;
endmodule
`default_nettype wire
